// File: design/srpd_pkg.sv
// ============================================================
// Shared constants and types for self-refresh / power-down
package srpd_pkg;

   // Clock rate in MHz
   localparam int CLK_MHZ            = 40;
   // Least self-refresh stay and first internal refresh bound, ns
   localparam int TCKE_NS            = 75;
   localparam int TCKE_CYC           = (TCKE_NS * CLK_MHZ + 999) / 1000;
   // Command receiver turn-off delay after power-down entry, ns
   localparam int TCPDED_NS          = 50;
   localparam int TCPDED_CYC         = (TCPDED_NS * CLK_MHZ + 999) / 1000;
   // Internal refresh interval in self-refresh, ns (longest: round down)
   localparam int TREFI_NS           = 7800;
   localparam int TREFI_CYC          = (TREFI_NS * CLK_MHZ) / 1000;
   // Counter width for all timers
   localparam int TMR_W              = 16;
   // Bank count
   localparam int NUM_BANKS          = 8;
   // Mode bit positions
   localparam int MR1_DLL_DIS_BIT    = 0;
   localparam int MR0_PD_FAST_BIT    = 12;

   // Command encodings {cs_n, ras_n, cas_n, we_n}
   localparam logic [3:0] CMD_REF    = 4'h1;
   localparam logic [3:0] CMD_NOP    = 4'h7;

   // Device power states
   typedef enum logic [2:0] {
      SRPD_NORMAL,
      SRPD_SELF_REFRESH,
      SRPD_PRE_PD,
      SRPD_ACT_PD
   } srpd_state_t;

   // Command bus sample
   typedef struct packed {
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
   } srpd_cmd_t;

   // Status outputs
   typedef struct packed {
      logic dll_on;
      logic dll_reset;
      logic int_clk_en;
      logic cmd_rx_en;
      logic io_buf_en;
      logic refresh_req;
   } srpd_stat_t;

endpackage

// File: design/srpd_timer.sv
`timescale 1ns/1ps
// ============================================================
// Loadable down-counter; done is high once count reaches zero
module srpd_timer
   import srpd_pkg::*;
(
   // Clock and reset
   input  wire logic             ref_clk,
   input  wire logic             sys_rst,
   // Control
   input  wire logic             load,
   input  wire logic [TMR_W-1:0] load_val,
   // Status
   output logic                  done
);
   logic [TMR_W-1:0] count;  // Remaining cycles

   // Count down to zero, reload on request
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         count <= '0;
      else if (load)
         count <= load_val;
      else if (count != '0)
         count <= count - 16'h0001;
   end

   assign done = (count == '0);
endmodule // srpd_timer

// File: design/srpd_ctl.sv
`timescale 1ns/1ps
// ============================================================
// Summary of operation
// RULE_01: Low CS RAS CAS CKE, high WE: self-refresh.
// RULE_02: Controller precharges all, disables termination first.
// RULE_03: CKE stays low; stay at least tCKE.
// RULE_04: DLL off on entry, on plus reset exit.
// RULE_05: Self-refresh ignores all but CKE, reset.
// RULE_06: Internal refresh within tCKE, then own timer.
// RULE_07: Clock change after tCKSRE, stable tCKSRX before exit.
// RULE_08: CKE rise with NOP exits; wait tXS.
// RULE_09: Wait tXSDLL before DLL-needing commands.
// RULE_10: CKE high, termination off through tXSDLL.
// RULE_11: Re-entry needs tXS and extra refresh.
// RULE_12: Only NOP or deselect during tXS.
// RULE_13: CKE low with NOP enters power-down.
// RULE_14: Closed banks precharge, open banks active power-down.
// RULE_15: Buffers off; command receivers off after tCPDED.
// RULE_16: Slow-exit precharge power-down turns DLL off.
// RULE_17: CKE high with NOP exits; tXP, tXPDLL.
// RULE_18: Reset in power-down forces reset state.
// RULE_19: CKE held tCKE; stay under 9 intervals.
// RULE_20: Command-to-entry least delays per command.
// RULE_21: Refresh between exit and entry: tXP, tXPDLL.
// RULE_22: Early entry after refresh: NOPs until tRFC.
// RULE_23: Postponed refreshes done before self-refresh; max 8.
module srpd_ctl
   import srpd_pkg::*;
(
   // Clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 sys_rst,
   // Device pins from the controller
   input  wire logic                 reset_n,
   input  wire logic                 cke,
   input  wire srpd_cmd_t            cmd,
   // Mode register bits and core state
   input  wire logic                 mr1_dll_dis,
   input  wire logic                 mr0_pd_fast,
   input  wire logic [NUM_BANKS-1:0] bank_open,
   input  wire logic                 core_busy,
   // Status
   output srpd_state_t               pwr_state,
   output logic                      in_reset,
   output srpd_stat_t                stat
);
   // ============================================================
   // Pin synchronisers
   logic       rst_n_s1;      // First stage of reset pin
   logic       rst_n_s2;      // Synchronised reset pin
   logic       cke_s1;        // First stage of CKE
   logic       cke_s2;        // Synchronised CKE
   srpd_cmd_t  cmd_s1;        // First stage of command
   srpd_cmd_t  cmd_s2;        // Synchronised command
   logic       cke_prev;      // CKE seen on previous edge
   logic [NUM_BANKS-1:0] bank_s1;  // First stage of bank status
   logic [NUM_BANKS-1:0] bank_s2;  // Synchronised bank status

   // Two-flop capture of all pins
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         rst_n_s1 <= 1'h0;
         rst_n_s2 <= 1'h0;
         // CKE idles high in the normal state, so no false edge follows reset
         cke_s1   <= 1'h1;
         cke_s2   <= 1'h1;
         cmd_s1   <= 4'hF;
         cmd_s2   <= 4'hF;
         bank_s1  <= '0;
         bank_s2  <= '0;
         cke_prev <= 1'h1;
      end
      else
      begin
         rst_n_s1 <= reset_n;
         rst_n_s2 <= rst_n_s1;
         cke_s1   <= cke;
         cke_s2   <= cke_s1;
         cmd_s1   <= cmd;
         cmd_s2   <= cmd_s1;
         bank_s1  <= bank_open;
         bank_s2  <= bank_s1;
         cke_prev <= cke_s2;
      end
   end

   // ============================================================
   // Command decode
   logic is_nop;       // NOP or deselect
   logic sre_cmd;      // Self-refresh entry
   logic pd_entry;     // Power-down entry
   logic exit_cmd;     // Exit from either low-power state
   logic all_closed;   // No bank open

   // Deselect or NOP
   function automatic logic nop_like(input srpd_cmd_t c);
      nop_like = c.cs_n || ({c.ras_n, c.cas_n, c.we_n} == 3'h7);
   endfunction

   assign is_nop     = nop_like(cmd_s2);
   // Refresh encoding registered with CKE falling
   assign sre_cmd    = cke_prev && !cke_s2 && (cmd_s2 == CMD_REF);  // see RULE_01
   assign pd_entry   = cke_prev && !cke_s2 && is_nop;               // see RULE_13
   assign exit_cmd   = !cke_prev && cke_s2 && is_nop;               // see RULE_08 see RULE_17
   assign all_closed = (bank_s2 == '0);

   // ============================================================
   // Timers
   logic tcke_load;    // Start least stay / first refresh window
   logic tcke_done;
   logic cpded_load;   // Start receiver turn-off delay
   logic cpded_done;
   logic refi_load;    // Restart internal refresh interval
   logic refi_done;

   srpd_timer u_tcke (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .load     (tcke_load),
      .load_val (TMR_W'(TCKE_CYC)),
      .done     (tcke_done)
   );

   srpd_timer u_cpded (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .load     (cpded_load),
      .load_val (TMR_W'(TCPDED_CYC)),
      .done     (cpded_done)
   );

   // Loaded one short: done shows while count is zero and the reload comes one cycle later, giving an exact interval
   srpd_timer u_refi (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .load     (refi_load),
      .load_val (TMR_W'(TREFI_CYC - 1)),
      .done     (refi_done)
   );

   // ============================================================
   // Power state machine
   srpd_state_t next_state;   // Next power state
   logic        pd_pending;   // Entry taken, waiting for core idle
   logic        dll_was_on;   // DLL enabled when self-refresh began
   logic        first_ref;    // First internal refresh issued

   // Next-state selection
   always_comb
   begin
      next_state = pwr_state;
      case (pwr_state)
         SRPD_NORMAL:
         begin
            if (sre_cmd)
               next_state = SRPD_SELF_REFRESH;
            else if ((pd_entry || pd_pending) && !core_busy)
               // Closed banks pick precharge mode, open ones active mode
               next_state = all_closed ? SRPD_PRE_PD : SRPD_ACT_PD;  // see RULE_14
         end
         SRPD_SELF_REFRESH:
         begin
            // Only a CKE rise with NOP or deselect counts here; stay is at least tCKE
            if (exit_cmd && tcke_done)  // see RULE_05 see RULE_03
               next_state = SRPD_NORMAL;
         end
         SRPD_PRE_PD,
         SRPD_ACT_PD:
         begin
            if (exit_cmd)
               next_state = SRPD_NORMAL;
         end
         default:
            next_state = SRPD_NORMAL;
      endcase
   end

   // State register; reset pin low overrides any state
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !rst_n_s2)  // see RULE_18
         pwr_state <= SRPD_NORMAL;
      else
         pwr_state <= next_state;
   end

   // Reset state flag
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         in_reset <= 1'h1;
      else
         in_reset <= !rst_n_s2;
   end

   // Power-down entry held while core commands finish
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !rst_n_s2)
         pd_pending <= 1'h0;
      else if (pwr_state != SRPD_NORMAL || exit_cmd)
         pd_pending <= 1'h0;
      else if (pd_entry && core_busy)
         pd_pending <= 1'h1;
   end

   // Timer loads
   assign tcke_load  = (pwr_state == SRPD_NORMAL) && (next_state == SRPD_SELF_REFRESH);
   assign cpded_load = (pwr_state == SRPD_NORMAL) && (next_state != SRPD_NORMAL);
   // Reload on entry too, so a quick re-entry never inherits a part-run interval
   assign refi_load  = (pwr_state == SRPD_SELF_REFRESH) && (!first_ref || refi_done);

   // ============================================================
   // Self-refresh internal refresh and DLL handling
   logic in_sr;        // In self-refresh
   logic in_pd;        // In either power-down
   assign in_sr = (pwr_state == SRPD_SELF_REFRESH);
   assign in_pd = (pwr_state == SRPD_PRE_PD) || (pwr_state == SRPD_ACT_PD);

   // Status flip-flops, gathered into the status struct at the end
   logic refresh_pulse;  // Internal refresh request
   logic dll_run;        // DLL enable
   logic dll_rst_pulse;  // DLL reset on exit
   logic clk_run;        // Internal clock enable
   logic buf_on;         // Input and output buffers enabled
   logic rx_on;          // Command receivers enabled

   // First refresh on the second cycle in self-refresh, then one per interval
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         first_ref     <= 1'h0;
         refresh_pulse <= 1'h0;
      end
      else
      begin
         first_ref     <= in_sr;
         refresh_pulse <= refi_load;  // see RULE_06
      end
   end

   // Remember DLL mode at self-refresh entry
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         dll_was_on <= 1'h0;
      else if (tcke_load)
         dll_was_on <= !mr1_dll_dis;
   end

   // DLL enable and exit-time DLL reset pulse
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst || !rst_n_s2)
      begin
         dll_run       <= 1'h0;
         dll_rst_pulse <= 1'h0;
      end
      else
      begin
         // Off in self-refresh, off in slow-exit precharge power-down
         dll_run       <= !mr1_dll_dis && !(next_state == SRPD_SELF_REFRESH)
                          && !(next_state == SRPD_PRE_PD && !mr0_pd_fast);  // see RULE_04 see RULE_16
         dll_rst_pulse <= in_sr && (next_state == SRPD_NORMAL) && dll_was_on;  // see RULE_04
      end
   end

   // ============================================================
   // Clock and buffer gating
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         clk_run <= 1'h1;
         buf_on  <= 1'h1;
         rx_on   <= 1'h1;
      end
      else
      begin
         clk_run <= (next_state != SRPD_SELF_REFRESH);  // see RULE_05
         buf_on  <= !(in_pd || in_sr) || exit_cmd;      // see RULE_15
         // Receivers stay on through the tCPDED window
         rx_on   <= (pwr_state == SRPD_NORMAL) || !cpded_done
                    || exit_cmd;                        // see RULE_15
      end
   end

   // ============================================================
   // Status output; one driver for the whole struct
   assign stat = '{dll_on:      dll_run,
                   dll_reset:   dll_rst_pulse,
                   int_clk_en:  clk_run,
                   cmd_rx_en:   rx_on,
                   io_buf_en:   buf_on,
                   refresh_req: refresh_pulse};
endmodule // srpd_ctl

// File: test/srpd_ctl_props.sv
`timescale 1ns/1ps
// ==========
// Power-state checker
module srpd_ctl_props
   import srpd_pkg::*;
(
   // Clock and reset
   input wire logic                 ref_clk,
   input wire logic                 sys_rst,
   // Pins
   input wire logic                 reset_n,
   input wire logic                 cke,
   input wire srpd_cmd_t            cmd,
   // Mode and core
   input wire logic                 mr1_dll_dis,
   input wire logic                 mr0_pd_fast,
   input wire logic [NUM_BANKS-1:0] bank_open,
   input wire logic                 core_busy,
   // Status
   input wire srpd_state_t          pwr_state,
   input wire logic                 in_reset,
   input wire srpd_stat_t           stat
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   // Entry command and state entry
   sequence s_sr_cmd;
      $fell(cke) && cmd == CMD_REF && !in_reset && pwr_state == SRPD_NORMAL;
   endsequence
   sequence s_sr_in;
      $rose(pwr_state == SRPD_SELF_REFRESH);
   endsequence
   property p_sr_entry; s_sr_cmd |-> ##[1:4] pwr_state == SRPD_SELF_REFRESH; endproperty
   property p_sr_clk; pwr_state == SRPD_SELF_REFRESH |-> !stat.int_clk_en; endproperty
   property p_sr_dll; s_sr_in |-> !stat.dll_on; endproperty
   property p_sr_ref; s_sr_in |-> ##[0:3] stat.refresh_req; endproperty
   property p_sr_hold;
      (pwr_state == SRPD_SELF_REFRESH && !cke && reset_n)[*4] |=> pwr_state == SRPD_SELF_REFRESH;
   endproperty
   property p_sr_exit;
      $fell(pwr_state == SRPD_SELF_REFRESH) && !in_reset && !mr1_dll_dis |-> ##[0:1] stat.dll_reset;
   endproperty
   property p_pd_rx;
      $rose(pwr_state inside {SRPD_PRE_PD, SRPD_ACT_PD}) |-> ##[0:3] !stat.cmd_rx_en;
   endproperty
   property p_pd_slow; (pwr_state == SRPD_PRE_PD && !mr0_pd_fast)[*2] |-> !stat.dll_on; endproperty
   property p_act_dll; (pwr_state == SRPD_ACT_PD && !mr1_dll_dis)[*2] |-> stat.dll_on; endproperty
   property p_rst; in_reset[*2] |-> pwr_state == SRPD_NORMAL; endproperty
   a_sr_entry: assert property (p_sr_entry) else $error("no entry");
   a_sr_clk: assert property (p_sr_clk) else $error("clock on");
   a_sr_dll: assert property (p_sr_dll) else $error("dll on");
   a_sr_ref: assert property (p_sr_ref) else $error("no refresh");
   a_sr_hold: assert property (p_sr_hold) else $error("left early");
   a_sr_exit: assert property (p_sr_exit) else $error("no dll reset");
   a_pd_rx: assert property (p_pd_rx) else $error("rx on");
   a_pd_slow: assert property (p_pd_slow) else $error("dll on");
   a_act_dll: assert property (p_act_dll) else $error("dll off");
   a_rst: assert property (p_rst) else $error("not normal");
endmodule // srpd_ctl_props
bind srpd_ctl srpd_ctl_props i_srpd_ctl_props (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .reset_n(reset_n), .cke(cke), .cmd(cmd), .mr1_dll_dis(mr1_dll_dis),
   .mr0_pd_fast(mr0_pd_fast), .bank_open(bank_open), .core_busy(core_busy),
   .pwr_state(pwr_state), .in_reset(in_reset), .stat(stat));

// File: test/srpd_ctl_model.sv
`timescale 1ns/1ps
// ==========
// Memory controller side: drives CKE and commands
module srpd_ctl_model
   import srpd_pkg::*;
(
   // Clock
   input wire logic ref_clk,
   // Pins
   output srpd_cmd_t ref_cmd,
   output logic      ref_cke
);
   initial
   begin
      ref_cke = 1'b1;
      ref_cmd = CMD_NOP;
   end
   // CKE change with a command, then NOPs; CKE held past tCKE
   task automatic step(input logic k, input logic [3:0] c);
      @(posedge ref_clk);
      ref_cke <= k;
      ref_cmd <= c;
      @(posedge ref_clk);
      ref_cmd <= CMD_NOP;
      repeat (TCKE_CYC + 3) @(posedge ref_clk);
   endtask
   // Command bus is don't care: alternates NOP and refresh every cycle
   task automatic scramble(input int n);
      repeat (n)
      begin
         @(posedge ref_clk);
         ref_cmd <= ref_cmd ^ 4'h6;
      end
      @(posedge ref_clk);
      ref_cmd <= CMD_NOP;
   endtask
endmodule // srpd_ctl_model

// File: test/tb.sv
`timescale 1ns/1ps
// ==========
// Testbench
module tb;
   import srpd_pkg::*;
   logic ref_clk, sys_rst, reset_n, mr1_dll_dis, mr0_pd_fast, core_busy, cke, in_reset;
   logic [NUM_BANKS-1:0] bank_open;
   srpd_cmd_t   cmd;
   srpd_state_t pwr_state;
   srpd_stat_t  stat;
   int error_cnt, comparisons, ref_cnt, dr_cnt;
   int cyc, last_ref, ref_gap;
   srpd_ctl i_srpd_ctl (.ref_clk(ref_clk), .sys_rst(sys_rst), .reset_n(reset_n), .cke(cke),
      .cmd(cmd), .mr1_dll_dis(mr1_dll_dis), .mr0_pd_fast(mr0_pd_fast), .bank_open(bank_open),
      .core_busy(core_busy), .pwr_state(pwr_state), .in_reset(in_reset), .stat(stat));
   srpd_ctl_model i_srpd_ctl_model (.ref_clk(ref_clk), .ref_cmd(cmd), .ref_cke(cke));
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Pulse counters
   always @(negedge ref_clk)
   begin
      cyc++;
      if (stat.refresh_req === 1'b1)
      begin
         ref_cnt++;
         ref_gap = cyc - last_ref;
         last_ref = cyc;
      end
      if (stat.dll_reset === 1'b1) dr_cnt++;
   end
   task automatic check(input string nm, input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("wrong value %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic wait_state(input srpd_state_t s);
      for (int i = 0; i < 20 && pwr_state !== s; i++) @(negedge ref_clk);
      check("pwr_state", pwr_state, s);
   endtask
   task automatic t_self_refresh(input logic dis);
      @(posedge ref_clk);
      mr1_dll_dis <= dis;
      bank_open <= '0;
      i_srpd_ctl_model.step(1'b1, CMD_REF);
      ref_cnt = 0;
      dr_cnt = 0;
      i_srpd_ctl_model.step(1'b0, CMD_REF);
      wait_state(SRPD_SELF_REFRESH);
      check("int_clk_en", stat.int_clk_en, 0);
      check("dll_on", stat.dll_on, 0);
      i_srpd_ctl_model.scramble(TREFI_CYC + 4);
      check("refreshes", ref_cnt, 2);
      check("refresh_gap", ref_gap, 16'(TREFI_CYC));
      check("pwr_state", pwr_state, SRPD_SELF_REFRESH);
      i_srpd_ctl_model.step(1'b1, CMD_NOP);
      wait_state(SRPD_NORMAL);
      @(negedge ref_clk);
      check("dll_reset", dr_cnt, !dis);
      check("dll_on", stat.dll_on, !dis);
   endtask
   task automatic t_pd(input logic [7:0] b, input logic f, input logic busy,
                       input srpd_state_t s, input logic dll);
      @(posedge ref_clk);
      bank_open <= b;
      mr0_pd_fast <= f;
      core_busy <= busy;
      i_srpd_ctl_model.step(1'b0, CMD_NOP);
      if (busy)
      begin
         check("pwr_state", pwr_state, SRPD_NORMAL);
         core_busy <= 1'b0;
      end
      wait_state(s);
      repeat (4) @(negedge ref_clk);
      check("cmd_rx_en", stat.cmd_rx_en, 0);
      check("io_buf_en", stat.io_buf_en, 0);
      check("dll_on", stat.dll_on, dll);
      i_srpd_ctl_model.step(1'b1, CMD_NOP);
      wait_state(SRPD_NORMAL);
      check("cmd_rx_en", stat.cmd_rx_en, 1);
      check("io_buf_en", stat.io_buf_en, 1);
   endtask
   task automatic t_rst_pd();
      i_srpd_ctl_model.step(1'b0, CMD_NOP);
      wait_state(SRPD_PRE_PD);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      wait_state(SRPD_NORMAL);
      check("in_reset", in_reset, 1);
      i_srpd_ctl_model.step(1'b1, CMD_NOP);
      reset_n <= 1'b1;
      repeat (5) @(negedge ref_clk);
      check("in_reset", in_reset, 0);
   endtask
   task automatic give_verdict();
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Watchdog
   initial
   begin
      #250000;
      error_cnt++;
      give_verdict();
   end
   // Main sequence
   initial
   begin
      sys_rst = 1'b1;
      reset_n = 1'b1;
      mr1_dll_dis = 1'b0;
      mr0_pd_fast = 1'b0;
      core_busy = 1'b0;
      bank_open = 8'h00;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      repeat (4) @(posedge ref_clk);
      t_self_refresh(1'b0);
      t_pd(8'h00, 1'b0, 1'b0, SRPD_PRE_PD, 1'b0);
      t_pd(8'h00, 1'b1, 1'b1, SRPD_PRE_PD, 1'b1);
      t_pd(8'h04, 1'b0, 1'b0, SRPD_ACT_PD, 1'b1);
      t_pd(8'h00, 1'b0, 1'b0, SRPD_PRE_PD, 1'b0);
      t_rst_pd();
      t_self_refresh(1'b1);
      give_verdict();
   end
endmodule // tb
